// file: bench/scdma_mem_model.sv
// memory partner: grants requests at once or after one wait cycle
`timescale 1ns/100ps
module scdma_mem_model (
  // clocking
  input wire logic clk,
  input wire logic rst,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  output logic mem_gnt,
  output logic [15:0] mem_rdata,
  // pacing
  input wire logic slow
);
  logic wait_ff;
  logic [15:0] last_ff;
  // ==========================================================================
  // pacing: a slow memory holds each request off for one cycle
  always_ff @(posedge clk) begin
    if (rst) wait_ff <= 1'b0;
    else wait_ff <= slow && mem_req && !wait_ff;
  end
  // idle data bus shows the inverse of its last value, never a stale word
  always_ff @(posedge clk) begin
    if (rst) last_ff <= 16'h0;
    else last_ff <= mem_rdata;
  end
  assign mem_gnt = mem_req && (!slow || wait_ff);
  assign mem_rdata = (mem_gnt && !mem_we) ? (mem_addr ^ 16'h5a5a) : ~last_ff;
endmodule

// file: bench/scdma_top_properties.sv
// port checker for the six-channel transfer controller
`timescale 1ns/100ps
module scdma_top_properties (
  // clocking
  input wire logic clk,
  input wire logic rst,
  // sources and routing select
  input wire logic [1:0] interrupt_route_select,
  input wire logic second_timer_interrupt,
  input wire logic port1_receive_interrupt,
  input wire logic port1_transmit_interrupt,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic mem_gnt,
  input wire logic cpu_hold,
  // status
  input wire logic [5:0] chan_active,
  input wire logic [5:0] chan_irq,
  input wire logic [3:0] shared_irq
);
  logic rd_ff, rst_ff;
  logic [1:0] route_ff;
  logic [2:0] src_ff;
  logic [5:0] irq_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // one-cycle history of the causes of the registered outputs
  always_ff @(posedge clk) begin
    rd_ff <= mem_req && mem_gnt && !mem_we;
    rst_ff <= rst;
    route_ff <= interrupt_route_select;
    src_ff <= {port1_transmit_interrupt, port1_receive_interrupt, second_timer_interrupt};
    irq_ff <= chan_irq;
  end
  sequence s_rd_done;
    mem_req && !mem_we && mem_gnt;
  endsequence
  sequence s_wr_up;
    mem_req && mem_we;
  endsequence
  a_req_stands: assert property (mem_req && !mem_gnt |=> mem_req && $stable(mem_addr)
    && $stable(mem_we)) else $error("request changed before grant");
  a_dma_over_cpu: assert property (mem_req |-> cpu_hold)
    else $error("cpu not held during transfer");
  a_read_then_write: assert property (s_rd_done |=> s_wr_up)
    else $error("read not followed by write");
  a_irq_after_read: assert property (chan_irq != 6'h0 |-> rd_ff)
    else $error("interrupt without a read grant");
  a_irq_pulse: assert property (chan_irq != 6'h0 |=> chan_irq == 6'h0)
    else $error("interrupt longer than one cycle");
  a_route_base: assert property (!rst_ff && route_ff != 2'h1 && route_ff != 2'h2
    |-> shared_irq == {src_ff, 1'b0}) else $error("base routing wrong");
  a_route_ch23: assert property (!rst_ff && route_ff == 2'h1
    |-> shared_irq == {irq_ff[3:2], src_ff[0], 1'b0}) else $error("ch2/3 routing wrong");
  a_route_all: assert property (!rst_ff && route_ff == 2'h2
    |-> shared_irq == irq_ff[3:0]) else $error("ch0-3 routing wrong");
  a_reset_quiet: assert property (rst_ff |-> shared_irq == 4'h0 && !mem_req
    && chan_active == 6'h0) else $error("outputs live after reset");
endmodule
bind scdma_top scdma_top_properties i_props (.clk(clk), .rst(rst),
  .interrupt_route_select(interrupt_route_select), .second_timer_interrupt(second_timer_interrupt),
  .port1_receive_interrupt(port1_receive_interrupt),
  .port1_transmit_interrupt(port1_transmit_interrupt), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_gnt(mem_gnt), .cpu_hold(cpu_hold), .chan_active(chan_active),
  .chan_irq(chan_irq), .shared_irq(shared_irq));

// file: bench/tb_scdma_top.sv
// self-checking bench for the six-channel transfer controller
`timescale 1ns/100ps
module tb_scdma_top;
  import scdma_pkg::*;
  typedef struct {logic [1:0] s, d; logic dw, ie, im, ab; logic [15:0] cnt; logic [7:0] frm;
    int nw; logic [15:0] last; int ni;} scdma_row_t;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, slow = 1'b0, tint = 1'b0, prx = 1'b0, ptx = 1'b0;
  scdma_chan_cfg_t chan_cfg [6];
  scdma_block_t chan_setup, global_reload;
  scdma_index_t index_regs;
  logic [5:0] chan_load = 6'h0;
  logic [1:0] route = 2'h2;
  logic [6:0] pins = 7'h0;
  logic mem_req, mem_we, mem_gnt, cpu_hold;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, last_rd;
  logic [5:0] chan_active, chan_irq;
  logic [3:0] shared_irq;
  logic [15:0] rq[$], wq[$];
  int failures = 0, samples_checked = 0, nirq = 0;
  logic [3:0] codes [7] = '{SYNC_P0_RX, SYNC_P0_TX, SYNC_P1_RX, SYNC_P1_TX, SYNC_TIMER0,
    SYNC_EXT3, SYNC_TIMER1};
  logic [15:0] exp_route [4] = '{16'ha, 16'h2, 16'h0, 16'ha};
  // ==========================================================================
  // block table: steps, doubleword, interrupt bits, counts, writes, last dest, interrupts
  // the last row steps its destination through index pair b
  scdma_row_t rows [6] = '{
    '{STEP_INC, STEP_INC, 0, 1, 0, 0, 16'h2, 8'h0, 3, 16'h202, 1},
    '{STEP_DEC, STEP_INDEX, 0, 1, 1, 0, 16'h1, 8'h1, 4, 16'h218, 2},
    '{STEP_INC, STEP_INC, 1, 0, 1, 0, 16'h0, 8'h0, 2, 16'h201, 0},
    '{STEP_KEEP, STEP_KEEP, 0, 1, 0, 0, 16'h0, 8'hff, 256, 16'h200, 1},
    '{STEP_INC, STEP_INC, 0, 1, 1, 1, 16'h3, 8'h0, 4, 16'h203, 2},
    '{STEP_INC, STEP_INDEX, 0, 1, 0, 0, 16'h1, 8'h1, 4, 16'h222, 1}};
  always #5 clk = ~clk;
  scdma_top i_dut (.clk(clk), .rst(rst), .ce(ce), .chan_cfg(chan_cfg), .chan_load(chan_load),
    .chan_setup(chan_setup), .global_reload(global_reload), .index_regs(index_regs),
    .interrupt_route_select(route), .sync_event_pins(pins), .second_timer_interrupt(tint),
    .port1_receive_interrupt(prx), .port1_transmit_interrupt(ptx), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_gnt(mem_gnt),
    .mem_rdata(mem_rdata), .cpu_hold(cpu_hold), .chan_active(chan_active),
    .chan_irq(chan_irq), .shared_irq(shared_irq));
  scdma_mem_model i_mem (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata), .slow(slow));
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cfg(int c, logic [1:0] s, d, logic hp, au, ab, ie, im, dw, logic [3:0] sy);
    chan_cfg[c] = {1'b1, hp, s, d, 2'b00, au, ab, ie, im, dw, sy};
  endtask
  task automatic ld(int c, logic [15:0] src, dst, cnt, logic [7:0] frm);
    chan_setup = {src, dst, cnt, frm};
    chan_load[c] = 1'b1;
    @(negedge clk);
    chan_load = 6'h0;
    @(negedge clk); // one quiet edge so a following load never re-raises the strobe at once
  endtask
  // bounded wait until every channel has finished its block
  task automatic drain();
    for (int i = 0; i < 3000 && chan_active !== 6'h0; i++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask
  task automatic clr();
    rq.delete();
    wq.delete();
    nirq = 0;
  endtask
  // log settled accesses mid-cycle; each write must carry the word of its read
  always @(negedge clk) begin
    if (chan_irq !== 6'h0) nirq++;
    if (mem_req && mem_gnt && !mem_we) begin
      rq.push_back(mem_addr);
      last_rd = mem_rdata;
    end
    if (mem_req && mem_gnt && mem_we) begin
      wq.push_back(mem_addr);
      chk("wdata", mem_wdata, last_rd);
    end
  end
  // watchdog: the whole sequence needs well under this span
  initial begin
    #300000;
    failures++;
    give_verdict();
  end
  initial begin
    foreach (chan_cfg[i]) chan_cfg[i] = '0;
    chan_setup = '0;
    global_reload = '0;
    index_regs = {16'h4, 16'h1, 16'h10, 16'h20};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("shared", 16'(shared_irq), 16'h0);
    foreach (rows[r]) begin
      clr();
      slow = r[0];
      cfg(0, rows[r].s, rows[r].d, 0, 0, rows[r].ab, rows[r].ie, rows[r].im, rows[r].dw, 4'h0);
      chan_cfg[0].dest_index_select = (r == 5);
      ld(0, 16'h100, 16'h200, rows[r].cnt, rows[r].frm);
      drain();
      chk("writes", 16'(wq.size()), 16'(rows[r].nw));
      chk("last dst", wq[$], rows[r].last);
      chk("irqs", 16'(nirq), 16'(rows[r].ni));
    end
    // each sync code holds its channel until its own pin rises
    foreach (codes[i]) begin
      clr();
      cfg(5, STEP_INC, STEP_INC, 0, 0, 0, 0, 0, 0, codes[i]);
      ld(5, 16'h100, 16'h200, 16'h0, 8'h0);
      repeat (8) @(negedge clk);
      chk("early", 16'(wq.size()), 16'h0);
      pins[i] = 1'b1;
      drain();
      pins[i] = 1'b0;
      chk("synced", 16'(wq.size()), 16'h1);
    end
    // one event releases a low channel and two high ones together
    clr();
    route = 2'h1;
    cfg(1, STEP_INC, STEP_INC, 0, 0, 0, 1, 0, 0, SYNC_TIMER0);
    cfg(2, STEP_INC, STEP_INC, 1, 0, 0, 1, 0, 0, SYNC_TIMER0);
    cfg(3, STEP_INC, STEP_INC, 1, 0, 0, 1, 0, 0, SYNC_TIMER0);
    ld(1, 16'h100, 16'h200, 16'h0, 8'h0);
    ld(2, 16'h300, 16'h200, 16'h0, 8'h0);
    ld(3, 16'h400, 16'h200, 16'h0, 8'h0);
    pins[4] = 1'b1;
    drain();
    pins[4] = 1'b0;
    chk("high pair", 16'(rq[0][11:8] + rq[1][11:8]), 16'h7);
    chk("low last", rq[2], 16'h100);
    // reload values written after the block began serve the next block
    clr();
    cfg(0, STEP_INC, STEP_INC, 0, 1, 0, 0, 0, 0, SYNC_NONE);
    ld(0, 16'h100, 16'h200, 16'h0, 8'h0);
    global_reload = {16'h500, 16'h600, 16'h0, 8'h0};
    repeat (12) @(negedge clk);
    chk("first dst", wq[0], 16'h200);
    chk("reload dst", wq[1], 16'h600);
    chk("reload src", rq[2], 16'h500);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("stopped", 16'(chan_active), 16'h0);
    // a load offered while the clock enable is low must be ignored
    ce = 1'b0;
    ld(0, 16'h100, 16'h200, 16'h0, 8'h0);
    chk("frozen", 16'(chan_active), 16'h0);
    ce = 1'b1;
    // every route code with fixed base sources
    {ptx, prx, tint} = 3'b101;
    for (int r = 0; r < 4; r++) begin
      route = 2'(r);
      repeat (3) @(negedge clk);
      chk("route", 16'(shared_irq), exp_route[r]);
    end
    give_verdict();
  end
endmodule

// file: rtl/scdma_pkg.sv
// constants, types and operation summary for the six-channel transfer controller
// ==========================================================================
// Operation
// - each channel is set high or low priority on its own
// - channels of equal priority are served in round-robin order
// - transfer addresses use one fixed map, blind to processor mapping bits
// - source and destination adjust separately: keep, increment, decrement or index
// - auto reload restores source, destination and count from globals at block end
// - each channel keeps an 8-bit frame counter, at most 0ffh
// - frame count zero, the reset value, means a single frame
// - frame counter decrements on the last read of each frame except the final one
// - with auto reload the frame counter reloads from its global after the last frame
// - 16-bit element counter, decremented per element read; 0ffffh gives 65536
// - with auto reload the element counter reloads from its global at block end
// - doubleword elements move as two 16-bit transfers, addresses stepped after each
// - index-select fields pick which shared element and frame index pair is used
// - all but the last transfer of a frame add the selected element index; in index mode a doubleword first half adds one instead
// - the last transfer of a frame adds the selected frame index instead
// - interrupt enable at zero blocks every channel interrupt
// - autobuffering interrupts at full buffer, and also at half when mode bit is 1
// - multi-frame with mode bit 0 interrupts only at block completion
// - multi-frame with mode bit 1 interrupts at every frame end and block end
// - a 4-bit sync field selects the triggering event; other codes are reserved
// - channels 0 to 3 share cpu interrupt lines 6, 7, 10 and 11
// - after reset the shared lines carry only their non-transfer sources; here the route select is an unreset input, so they follow its code
// - the route select field chooses which sources drive the shared lines
// - six independent channels each keep their own block context
// - transfer requests win over cpu requests for internal memory
package scdma_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_CH = 6;
  localparam int AW = 16;
  localparam int DW = 16;
  localparam int NUM_EVT = 7;

  // ==========================================================================
  // address step modes
  localparam logic [1:0] STEP_KEEP = 2'h0;
  localparam logic [1:0] STEP_INC = 2'h1;
  localparam logic [1:0] STEP_DEC = 2'h2;
  localparam logic [1:0] STEP_INDEX = 2'h3;

  // ==========================================================================
  // sync event codes and event vector positions
  localparam logic [3:0] SYNC_NONE = 4'h0;
  localparam logic [3:0] SYNC_P0_RX = 4'h1;
  localparam logic [3:0] SYNC_P0_TX = 4'h2;
  localparam logic [3:0] SYNC_P1_RX = 4'h5;
  localparam logic [3:0] SYNC_P1_TX = 4'h6;
  localparam logic [3:0] SYNC_TIMER0 = 4'hd;
  localparam logic [3:0] SYNC_EXT3 = 4'he;
  localparam logic [3:0] SYNC_TIMER1 = 4'hf;
  localparam int EVT_P0_RX = 0;
  localparam int EVT_P0_TX = 1;
  localparam int EVT_P1_RX = 2;
  localparam int EVT_P1_TX = 3;
  localparam int EVT_TIMER0 = 4;
  localparam int EVT_EXT3 = 5;
  localparam int EVT_TIMER1 = 6;

  // ==========================================================================
  // interrupt routing
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_CH23 = 2'h1;
  localparam logic [1:0] ROUTE_CH0123 = 2'h2;
  localparam logic [1:0] ROUTE_RESET = 2'h0;

  // ==========================================================================
  // reset values
  localparam logic [7:0] FRAME_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } scdma_state_t;

  typedef struct packed {
    logic enable;
    logic high_prio;
    logic [1:0] src_step;
    logic [1:0] dst_step;
    logic source_index_select;
    logic dest_index_select;
    logic auto_reload_enable;
    logic autobuffering_mode;
    logic interrupt_enable_bit;
    logic interrupt_mode_bit;
    logic doubleword;
    logic [3:0] sync_event_select;
  } scdma_chan_cfg_t;

  typedef struct packed {
    logic [AW-1:0] source;
    logic [AW-1:0] dest;
    logic [15:0] count;
    logic [7:0] frame;
  } scdma_block_t;

  typedef struct packed {
    logic [AW-1:0] element_index_a;
    logic [AW-1:0] element_index_b;
    logic [AW-1:0] frame_index_a;
    logic [AW-1:0] frame_index_b;
  } scdma_index_t;

endpackage

// file: rtl/scdma_rr_arb.sv
// round-robin picker over six channel requests
`timescale 1ns/100ps
module scdma_rr_arb (
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // requests and grant
  input wire logic [5:0] req,
  input wire logic take,
  output logic any,
  output logic [2:0] pick
);

  logic [2:0] last_ff;
  logic [2:0] idx;

  // search starts one past the last winner so no channel starves
  always_comb begin
    any = 1'b0;
    pick = 3'h0;
    for (int k = 1; k <= 6; k++) begin
      idx = 3'((32'(last_ff) + k) % 6);
      if (!any && req[idx]) begin
        any = 1'b1;
        pick = idx;
      end
    end
  end

  // pointer moves only when this group's winner is really taken
  always_ff @(posedge clk) begin
    if (rst) begin
      last_ff <= 3'h5;
    end else if (ce && take && any) begin
      last_ff <= pick;
    end
  end

endmodule

// file: rtl/scdma_sync.sv
// two-stage synchroniser for a group of asynchronous event lines
`timescale 1ns/100ps
module scdma_sync #(
  parameter int W = 1
) (
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // lines
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] hold_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      hold_ff <= '0;
    end else if (ce) begin
      meta_ff <= async_in;
      hold_ff <= meta_ff;
    end
  end

  assign sync_out = hold_ff;

endmodule

// file: rtl/scdma_top.sv
// six-channel memory transfer controller: arbitration, counting, addressing, interrupts
`timescale 1ns/100ps
module scdma_top (
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // channel configuration and setup
  input wire scdma_pkg::scdma_chan_cfg_t chan_cfg [6],
  input wire logic [5:0] chan_load,
  input wire scdma_pkg::scdma_block_t chan_setup,
  // shared reload, index and routing values
  input wire scdma_pkg::scdma_block_t global_reload,
  input wire scdma_pkg::scdma_index_t index_regs,
  input wire logic [1:0] interrupt_route_select,
  // sync event pins
  input wire logic [6:0] sync_event_pins,
  // non-transfer interrupt sources on the shared lines, same clock
  input wire logic second_timer_interrupt,
  input wire logic port1_receive_interrupt,
  input wire logic port1_transmit_interrupt,
  // internal memory port
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_gnt,
  input wire logic [15:0] mem_rdata,
  output logic cpu_hold,
  // status and interrupts
  output logic [5:0] chan_active,
  output logic [5:0] chan_irq,
  output logic [3:0] shared_irq
);
  import scdma_pkg::*;

  // ==========================================================================
  // state
  logic [15:0] src_ff [6];
  logic [15:0] dst_ff [6];
  logic [15:0] element_counter_ff [6];
  logic [15:0] elem_init_ff [6];
  logic [7:0] frame_count_ff [6];
  logic [5:0] active_ff;
  logic [5:0] pend_ff;
  logic [5:0] irq_ff;
  logic [3:0] shared_ff;
  scdma_state_t state_ff;
  logic [2:0] cur_ff;
  logic half_ff;
  logic last_ff;
  logic done_ff;
  logic req_ff;
  logic we_ff;
  logic hold_ff;
  logic [15:0] addr_ff;
  logic [15:0] data_ff;

  // ==========================================================================
  // event synchronisation
  logic [6:0] evt_sync;
  logic [6:0] evt_prev_ff;
  logic [6:0] evt_rise;
  logic [5:0] evt_hit;

  scdma_sync #(.W(7)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in(sync_event_pins),
    .sync_out(evt_sync)
  );

  // rising edges are taken from the second stage only
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_prev_ff <= '0;
    end else if (ce) begin
      evt_prev_ff <= evt_sync;
    end
  end

  assign evt_rise = evt_sync & ~evt_prev_ff;

  // map each channel's sync code onto an event; reserved codes never fire
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      case (chan_cfg[c].sync_event_select)
        SYNC_P0_RX: evt_hit[c] = evt_rise[EVT_P0_RX];
        SYNC_P0_TX: evt_hit[c] = evt_rise[EVT_P0_TX];
        SYNC_P1_RX: evt_hit[c] = evt_rise[EVT_P1_RX];
        SYNC_P1_TX: evt_hit[c] = evt_rise[EVT_P1_TX];
        SYNC_TIMER0: evt_hit[c] = evt_rise[EVT_TIMER0];
        SYNC_EXT3: evt_hit[c] = evt_rise[EVT_EXT3];
        SYNC_TIMER1: evt_hit[c] = evt_rise[EVT_TIMER1];
        default: evt_hit[c] = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // arbitration
  logic [5:0] ready;
  logic [5:0] req_hi;
  logic [5:0] req_lo;
  logic any_hi;
  logic any_lo;
  logic [2:0] pick_hi;
  logic [2:0] pick_lo;
  logic start;
  logic [2:0] pick;

  // unsynchronized channels are ready whenever active, so they run back to back
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ready[c] = active_ff[c] && ((chan_cfg[c].sync_event_select == SYNC_NONE)
                 || pend_ff[c]);
      req_hi[c] = ready[c] && chan_cfg[c].high_prio;
      req_lo[c] = ready[c] && !chan_cfg[c].high_prio;
    end
  end

  assign start = (state_ff == ST_IDLE) && (any_hi || any_lo);
  assign pick = any_hi ? pick_hi : pick_lo;

  scdma_rr_arb u_arb_hi (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .req(req_hi),
    .take(start),
    .any(any_hi),
    .pick(pick_hi)
  );

  scdma_rr_arb u_arb_lo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .req(req_lo),
    .take(start && !any_hi),
    .any(any_lo),
    .pick(pick_lo)
  );

  // ==========================================================================
  // address step: in index mode the first doubleword half moves by one word
  function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] mode,
                                            input logic [15:0] idx, input logic first_half);
    logic [15:0] r;
    r = a;
    case (mode)
      STEP_INC: r = a + 16'h0001;
      STEP_DEC: r = a - 16'h0001;
      STEP_INDEX: r = first_half ? a + 16'h0001 : a + idx;
      default: r = a;
    endcase
    return r;
  endfunction

  // selected index pair; frame index on the last transfer of a frame
  function automatic logic [15:0] pick_index(input logic sel, input logic last);
    logic [15:0] r;
    r = 16'h0000;
    if (last) begin
      r = sel ? index_regs.frame_index_b : index_regs.frame_index_a;
    end else begin
      r = sel ? index_regs.element_index_b : index_regs.element_index_a;
    end
    return r;
  endfunction

  scdma_chan_cfg_t cc;
  logic first_half;
  logic elem_last;
  logic blk_last;
  logic rd_done;
  logic wr_done;
  logic half_point;

  assign cc = chan_cfg[cur_ff];
  assign first_half = cc.doubleword && !half_ff;
  assign elem_last = (element_counter_ff[cur_ff] == 16'h0000);
  assign blk_last = elem_last && (frame_count_ff[cur_ff] == 8'h00);
  assign rd_done = (state_ff == ST_READ) && mem_gnt;
  assign wr_done = (state_ff == ST_WRITE) && mem_gnt;
  assign half_point = (element_counter_ff[cur_ff] == (elem_init_ff[cur_ff] >> 1));

  // ==========================================================================
  // transfer sequencer: one read then one write per word, fixed address map
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cur_ff <= 3'h0;
      half_ff <= 1'b0;
      last_ff <= 1'b0;
      done_ff <= 1'b0;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      addr_ff <= ADDR_RESET;
      data_ff <= 16'h0000;
    end else if (ce) begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            cur_ff <= pick;
            half_ff <= 1'b0;
            req_ff <= 1'b1;
            we_ff <= 1'b0;
            addr_ff <= src_ff[pick];
            state_ff <= ST_READ;
          end
        end
        ST_READ: begin
          if (mem_gnt) begin
            data_ff <= mem_rdata;
            last_ff <= elem_last && !first_half;
            done_ff <= blk_last && !first_half;
            we_ff <= 1'b1;
            addr_ff <= dst_ff[cur_ff];
            state_ff <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (mem_gnt) begin
            we_ff <= 1'b0;
            if (first_half) begin
              half_ff <= 1'b1;
              addr_ff <= src_ff[cur_ff];
              state_ff <= ST_READ;
            end else begin
              req_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          req_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // transfers hold off the cpu for internal memory while they run
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_ff <= 1'b0;
    end else if (ce) begin
      hold_ff <= start || (state_ff != ST_IDLE && !(wr_done && !first_half));
    end
  end

  // ==========================================================================
  // per-channel context: addresses, counters, activity, pending events
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        src_ff[c] <= ADDR_RESET;
        dst_ff[c] <= ADDR_RESET;
        element_counter_ff[c] <= COUNT_RESET;
        elem_init_ff[c] <= COUNT_RESET;
        frame_count_ff[c] <= FRAME_RESET;
      end
      active_ff <= '0;
      pend_ff <= '0;
    end else if (ce) begin
      for (int c = 0; c < NUM_CH; c++) begin
        // a new event wins over the clear made by the grant in the same cycle
        pend_ff[c] <= (pend_ff[c] && !(start && pick == 3'(c))) || evt_hit[c];
        if (chan_load[c]) begin
          src_ff[c] <= chan_setup.source;
          dst_ff[c] <= chan_setup.dest;
          element_counter_ff[c] <= chan_setup.count;
          elem_init_ff[c] <= chan_setup.count;
          frame_count_ff[c] <= chan_setup.frame;
          active_ff[c] <= chan_cfg[c].enable;
        end else if (!chan_cfg[c].enable) begin
          active_ff[c] <= 1'b0;
        end
      end
      if (rd_done && !chan_load[cur_ff]) begin
        src_ff[cur_ff] <= step_addr(src_ff[cur_ff], cc.src_step,
          pick_index(cc.source_index_select, elem_last && !first_half), first_half);
        if (!first_half) begin
          if (!elem_last) begin
            element_counter_ff[cur_ff] <= element_counter_ff[cur_ff] - 16'h0001;
          end else if (!blk_last) begin
            element_counter_ff[cur_ff] <= elem_init_ff[cur_ff];
            frame_count_ff[cur_ff] <= frame_count_ff[cur_ff] - 8'h01;
          end else if (cc.auto_reload_enable) begin
            element_counter_ff[cur_ff] <= global_reload.count;
            elem_init_ff[cur_ff] <= global_reload.count;
            frame_count_ff[cur_ff] <= global_reload.frame;
          end
        end
      end
      if (wr_done && !chan_load[cur_ff]) begin
        if (done_ff && cc.auto_reload_enable) begin
          // source and destination globals are sampled only here, so later rewrites serve the next block
          src_ff[cur_ff] <= global_reload.source;
          dst_ff[cur_ff] <= global_reload.dest;
        end else begin
          dst_ff[cur_ff] <= step_addr(dst_ff[cur_ff], cc.dst_step,
            pick_index(cc.dest_index_select, last_ff), first_half);
          if (done_ff) begin
            active_ff[cur_ff] <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================================
  // channel interrupts: one-cycle pulse when an element read reaches a mark
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= '0;
    end else if (ce) begin
      irq_ff <= '0;
      if (rd_done && !first_half && cc.interrupt_enable_bit) begin
        if (cc.autobuffering_mode) begin
          irq_ff[cur_ff] <= blk_last || (cc.interrupt_mode_bit && half_point && !elem_last);
        end else if (cc.interrupt_mode_bit) begin
          irq_ff[cur_ff] <= elem_last;
        end else begin
          irq_ff[cur_ff] <= blk_last;
        end
      end
    end
  end

  // shared cpu lines 6, 7, 10, 11; reserved codes leave only the base sources
  always_ff @(posedge clk) begin
    if (rst) begin
      shared_ff <= '0;
    end else if (ce) begin
      if (interrupt_route_select == ROUTE_CH0123) begin
        shared_ff <= {irq_ff[3], irq_ff[2], irq_ff[1], irq_ff[0]};
      end else if (interrupt_route_select == ROUTE_CH23) begin
        shared_ff <= {irq_ff[3], irq_ff[2], second_timer_interrupt, 1'b0};
      end else begin
        shared_ff <= {port1_transmit_interrupt, port1_receive_interrupt,
                      second_timer_interrupt, 1'b0};
      end
    end
  end

  // ==========================================================================
  // outputs
  assign mem_req = req_ff;
  assign mem_we = we_ff;
  assign mem_addr = addr_ff;
  assign mem_wdata = data_ff;
  assign cpu_hold = hold_ff;
  assign chan_active = active_ff;
  assign chan_irq = irq_ff;
  assign shared_irq = shared_ff;

endmodule
